// [hdl/gtu_params.svh]
// offsets, field positions and timing counts of the timer unit
// assumes pclk at 20 MHz and a 32-bit apb slave with one word per register
`ifndef GTU_PARAMS_SVH
`define GTU_PARAMS_SVH
`define GTU_CLK_NS 50
`define GTU_SLOW_RES_NS 400
`define GTU_FAST_RES_NS 200
`define GTU_SLOW_BASE ((`GTU_SLOW_RES_NS+`GTU_CLK_NS-1)/`GTU_CLK_NS)
`define GTU_FAST_BASE ((`GTU_FAST_RES_NS+`GTU_CLK_NS-1)/`GTU_CLK_NS)
`define GTU_NUM_TIMERS 5
`define GTU_NUM_PINS 7
`define GTU_CTL_W 20
`define GTU_CTL_BASE 8'h00
`define GTU_CNT_BASE 8'h14
`define GTU_CAPTURE_RELOAD_REG_OFS 8'h28
`define GTU_STATUS_OFS 8'h2C
`define GTU_F_MODE 1:0
`define GTU_F_DOWN 2
`define GTU_F_RUN 3
`define GTU_F_PRESC 6:4
`define GTU_F_GATE_LVL 7
`define GTU_F_EDGE 9:8
`define GTU_F_RELOAD 10
`define GTU_F_TGL_SRC 11
`define GTU_F_EXT_DIR 12
`define GTU_F_TGL_OUT 13
`define GTU_F_RL_TGL 14
`define GTU_F_OV_RELOAD 15
`define GTU_F_CAP_EN 16
`define GTU_F_CAP_CLR 17
`define GTU_F_CAP_EDGE 19:18
`define GTU_ST_S_TGL 8
`define GTU_ST_F_TGL 9
`define GTU_PIN_DIR 5
`define GTU_PIN_CAP 6
`endif

// [hdl/gtu_pkg.sv]
// types shared by the timer unit
// assumes gtu_params.svh is on the include path
`include "gtu_params.svh"
package gtu_pkg;
   typedef enum logic [1:0] {
      GTU_TIMER = 2'b00,
      GTU_GATED = 2'b01,
      GTU_COUNT = 2'b10,
      GTU_CAPRL = 2'b11
   } gtu_mode_t;

   typedef struct packed {
      logic capture_pin;
      logic slow_dir;
      logic fast_core;
      logic fast_aux;
      logic slow_aux_b;
      logic slow_core;
      logic slow_aux_a;
   } gtu_pins_t;

   typedef struct packed {
      logic [`GTU_NUM_TIMERS-1:0][15:0] cnt;
      logic [`GTU_NUM_TIMERS-1:0][`GTU_CTL_W-1:0] ctl;
      logic [15:0] capture_reload_reg;
      logic [`GTU_NUM_TIMERS-1:0] flags;
      logic s_tgl;
      logic s_tgl_p;
      logic f_tgl;
      logic f_tgl_p;
      logic pulse;
      logic [15:0] pre;
      logic [`GTU_NUM_PINS-1:0] sync1;
      logic [`GTU_NUM_PINS-1:0] sync2;
      logic [`GTU_NUM_PINS-1:0] prev;
      logic [31:0] rdata;
   } gtu_state_t;
endpackage

// [hdl/gtu_unit.sv]
// five-timer general purpose timer unit with apb register access
// assumes pins are asynchronous to pclk; apb master follows the standard
//
// Chosen here: the APB slave port and the register offsets.
`timescale 1ns/10ps
`default_nettype none
`include "gtu_params.svh"

module gtu_unit #(
   parameter int ADDR_W = 12
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire gtu_pkg::gtu_pins_t pins,
   output logic slow_toggle_out,
   output logic fast_toggle_out,
   output logic timebase_pulse,
   output logic [`GTU_NUM_TIMERS-1:0] irq_req
);
   import gtu_pkg::*;

   localparam int NT = `GTU_NUM_TIMERS;

   gtu_state_t q;
   gtu_state_t d;
   logic [NT-1:0] tick;
   logic [NT-1:0] en;
   logic [NT-1:0] ov;
   logic [NT-1:0] down;
   logic [NT-1:0] pedge;
   logic [NT-1:0] tedge;
   logic [NT-1:0] cap;
   logic [NT-1:0] rl;
   logic [NT-1:0][15:0] msk;
   logic [`GTU_NUM_PINS-1:0] rise;
   logic [`GTU_NUM_PINS-1:0] fall;
   logic s_rise;
   logic s_fall;
   logic f_rise;
   logic f_fall;
   logic fcap;
   logic wr;
   logic rd_setup;
   logic mapped;
   logic [7:0] a;

   function automatic logic esel(input logic [1:0] sel, input logic r,
                                 input logic f);
      esel = (sel[0] & r) | (sel[1] & f);
   endfunction

   assign wr = psel & penable & pwrite;
   assign rd_setup = psel & ~penable & ~pwrite;
   assign a = paddr[7:0];
   // zero wait states: read data is fetched in the setup phase
   assign pready = 1'b1;
   assign pslverr = psel & penable & ~mapped;
   assign prdata = q.rdata;
   assign slow_toggle_out = q.s_tgl & q.ctl[1][`GTU_F_TGL_OUT];
   assign fast_toggle_out = q.f_tgl & q.ctl[4][`GTU_F_TGL_OUT];
   assign timebase_pulse = q.pulse;
   assign irq_req = q.flags;

   // edges only from the second synchroniser stage onward
   assign rise = q.sync2 & ~q.prev;
   assign fall = ~q.sync2 & q.prev;
   assign s_rise = q.s_tgl & ~q.s_tgl_p;
   assign s_fall = ~q.s_tgl & q.s_tgl_p;
   assign f_rise = q.f_tgl & ~q.f_tgl_p;
   assign f_fall = ~q.f_tgl & q.f_tgl_p;

   always_comb begin
      mapped = (paddr[ADDR_W-1:8] == '0) && (a[1:0] == 2'h0) &&
               (a <= `GTU_STATUS_OFS);
   end

   always_comb begin
      d = q;
      tick = '0;
      en = '0;
      ov = '0;
      down = '0;
      pedge = '0;
      tedge = '0;
      cap = '0;
      rl = '0;
      msk = '0;
      fcap = 1'b0;
      d.sync1 = pins;
      d.sync2 = q.sync1;
      d.prev = q.sync2;
      d.pre = q.pre + 16'h0001;
      d.s_tgl_p = q.s_tgl;
      d.f_tgl_p = q.f_tgl;
      for (int i = 0; i < NT; i++) begin
         // power-of-two prescale taps one free counter for all timers
         msk[i] = (((i > 2) ? 16'(`GTU_FAST_BASE) : 16'(`GTU_SLOW_BASE))
                   << q.ctl[i][`GTU_F_PRESC]) - 16'h0001;
         tick[i] = (q.pre & msk[i]) == msk[i];
         pedge[i] = esel(q.ctl[i][`GTU_F_EDGE], rise[i], fall[i]);
         tedge[i] = (i == 3) ? esel(q.ctl[i][`GTU_F_EDGE], f_rise, f_fall)
                             : esel(q.ctl[i][`GTU_F_EDGE], s_rise, s_fall);
         case (gtu_mode_t'(q.ctl[i][`GTU_F_MODE]))
            GTU_TIMER: en[i] = q.ctl[i][`GTU_F_RUN] & tick[i];
            GTU_GATED: en[i] = q.ctl[i][`GTU_F_RUN] & tick[i] &
                  (q.sync2[i] == q.ctl[i][`GTU_F_GATE_LVL]);
            GTU_COUNT: en[i] = q.ctl[i][`GTU_F_RUN] &
                  (q.ctl[i][`GTU_F_TGL_SRC] ? tedge[i]
                                            : pedge[i]);
            default: en[i] = 1'b0;
         endcase
         down[i] = (i == 1 && q.ctl[i][`GTU_F_EXT_DIR])
                   ? q.sync2[`GTU_PIN_DIR] : q.ctl[i][`GTU_F_DOWN];
         ov[i] = en[i] & (down[i] ? (q.cnt[i] == 16'h0000)
                                  : (q.cnt[i] == 16'hFFFF));
         if (en[i]) begin
            d.cnt[i] = down[i] ? q.cnt[i] - 16'h0001
                               : q.cnt[i] + 16'h0001;
         end
         if ((i == 0 || i == 2) &&
             q.ctl[i][`GTU_F_MODE] == GTU_CAPRL) begin
            if (q.ctl[i][`GTU_F_RELOAD]) begin
               rl[i] = q.ctl[i][`GTU_F_RL_TGL] ? tedge[i] : pedge[i];
            end else begin
               cap[i] = pedge[i];
            end
         end
      end
      d.s_tgl = q.s_tgl ^ ov[1];
      d.f_tgl = q.f_tgl ^ ov[4];
      d.pulse = ov[4];
      if (cap[0]) begin
         d.cnt[0] = q.cnt[1];
      end
      if (cap[2]) begin
         d.cnt[2] = q.cnt[1];
      end
      // reload edges of opposite polarity alternate low and high times
      if (rl[0]) begin
         d.cnt[1] = q.cnt[0];
      end else if (rl[2]) begin
         d.cnt[1] = q.cnt[2];
      end
      if (ov[4] && q.ctl[4][`GTU_F_OV_RELOAD]) begin
         d.cnt[4] = q.capture_reload_reg;
      end
      fcap = q.ctl[3][`GTU_F_CAP_EN] &
             esel(q.ctl[3][`GTU_F_CAP_EDGE], rise[`GTU_PIN_CAP],
                  fall[`GTU_PIN_CAP]);
      if (fcap) begin
         d.capture_reload_reg = q.cnt[3];
         if (q.ctl[3][`GTU_F_CAP_CLR]) begin
            d.cnt[3] = 16'h0000;
         end
      end
      // new events win over a clear in the same cycle
      d.flags = q.flags | ov;
      if (wr) begin
         for (int i = 0; i < NT; i++) begin
            if (a == `GTU_CTL_BASE + 8'(4 * i)) begin
               d.ctl[i] = pwdata[`GTU_CTL_W-1:0];
            end
            if (a == `GTU_CNT_BASE + 8'(4 * i)) begin
               d.cnt[i] = pwdata[15:0];
            end
         end
         if (a == `GTU_CAPTURE_RELOAD_REG_OFS) begin
            d.capture_reload_reg = pwdata[15:0];
         end
         if (a == `GTU_STATUS_OFS) begin
            d.flags = (q.flags & ~pwdata[NT-1:0]) | ov;
         end
      end
      if (rd_setup) begin
         d.rdata = 32'h00000000;
         for (int i = 0; i < NT; i++) begin
            if (a == `GTU_CTL_BASE + 8'(4 * i)) begin
               d.rdata[`GTU_CTL_W-1:0] = q.ctl[i];
            end
            if (a == `GTU_CNT_BASE + 8'(4 * i)) begin
               d.rdata[15:0] = q.cnt[i];
            end
         end
         if (a == `GTU_CAPTURE_RELOAD_REG_OFS) begin
            d.rdata[15:0] = q.capture_reload_reg;
         end
         if (a == `GTU_STATUS_OFS) begin
            d.rdata[NT-1:0] = q.flags;
            d.rdata[`GTU_ST_S_TGL] = q.s_tgl;
            d.rdata[`GTU_ST_F_TGL] = q.f_tgl;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   a_slow_tick_rate: assert property (
      @(posedge pclk) disable iff (!presetn)
      (q.ctl[1][`GTU_F_PRESC] == 3'h0 && tick[1])
         |-> ##1 !tick[1] [*7] ##1 tick[1])
      else $error("slow tick spacing wrong");

   a_fast_tick_rate: assert property (
      @(posedge pclk) disable iff (!presetn)
      (q.ctl[4][`GTU_F_PRESC] == 3'h0 && tick[4])
         |-> ##1 !tick[4] [*3] ##1 tick[4])
      else $error("fast tick spacing wrong");

   a_core_toggle_flip: assert property (
      @(posedge pclk) disable iff (!presetn)
      ov[1] |=> q.s_tgl != $past(q.s_tgl))
      else $error("toggle latch missed a wrap");

   a_wrap_flag_set: assert property (
      @(posedge pclk) disable iff (!presetn)
      (ov[1] && q.ctl[1][`GTU_F_DOWN] == 1'b0 &&
       !q.ctl[1][`GTU_F_EXT_DIR] && !wr && !rl[0] && !rl[2])
         |=> q.flags[1] && q.cnt[1] == 16'h0000)
      else $error("wrap did not set flag or count");

   a_fast_wrap_pulse: assert property (
      @(posedge pclk) disable iff (!presetn)
      ov[4] |=> timebase_pulse ##1 (!timebase_pulse || $past(ov[4])))
      else $error("timebase pulse wrong");

   a_capture_copy: assert property (
      @(posedge pclk) disable iff (!presetn)
      (cap[0] && !wr) |=> q.cnt[0] == $past(q.cnt[1]))
      else $error("capture did not copy core");

   a_aux_halted: assert property (
      @(posedge pclk) disable iff (!presetn)
      (q.ctl[2][`GTU_F_MODE] == GTU_CAPRL && !cap[2] && !wr)
         |=> q.cnt[2] == $past(q.cnt[2]))
      else $error("aux counted while capture/reload");

   a_gate_closed: assert property (
      @(posedge pclk) disable iff (!presetn)
      (q.ctl[1][`GTU_F_MODE] == GTU_GATED &&
       q.sync2[1] != q.ctl[1][`GTU_F_GATE_LVL] && !wr && rl[2:0] == '0)
         |=> $stable(q.cnt[1]))
      else $error("core counted with gate closed");

   a_fast_clear: assert property (
      @(posedge pclk) disable iff (!presetn)
      (fcap && q.ctl[3][`GTU_F_CAP_CLR] && !wr)
         |=> q.cnt[3] == 16'h0000 && q.capture_reload_reg == $past(q.cnt[3]))
      else $error("capture or clear missed");

   a_ext_dir_down: assert property (
      @(posedge pclk) disable iff (!presetn)
      (en[1] && q.ctl[1][`GTU_F_EXT_DIR] && q.sync2[`GTU_PIN_DIR] && !wr &&
       rl[2:0] == '0) |=> q.cnt[1] == $past(q.cnt[1]) - 16'h0001)
      else $error("core ignored direction pin");

   a_core_count_up: assert property (
      @(posedge pclk) disable iff (!presetn)
      (en[1] && !down[1] && !wr && rl[2:0] == '0)
         |=> q.cnt[1] == $past(q.cnt[1]) + 16'h0001)
      else $error("core did not count up");

   a_reload_from_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      (rl[0] && !wr) |=> q.cnt[1] == $past(q.cnt[0]))
      else $error("core missed reload from aux a");

   a_reload_from_b: assert property (
      @(posedge pclk) disable iff (!presetn)
      (rl[2] && !rl[0] && !wr) |=> q.cnt[1] == $past(q.cnt[2]))
      else $error("core missed reload from aux b");

   a_fast_reload: assert property (
      @(posedge pclk) disable iff (!presetn)
      (ov[4] && q.ctl[4][`GTU_F_OV_RELOAD] && !wr)
         |=> q.cnt[4] == $past(q.capture_reload_reg))
      else $error("fast core missed reload");

   a_fast_toggle_flip: assert property (
      @(posedge pclk) disable iff (!presetn)
      ov[4] |=> q.f_tgl != $past(q.f_tgl))
      else $error("fast toggle missed a wrap");

   a_aux_a_halted: assert property (
      @(posedge pclk) disable iff (!presetn)
      (q.ctl[0][`GTU_F_MODE] == GTU_CAPRL && !cap[0] && !wr)
         |=> $stable(q.cnt[0]))
      else $error("aux a counted while capture/reload");

   a_capture_reload_reg_latch: assert property (
      @(posedge pclk) disable iff (!presetn)
      (fcap && !wr) |=> q.capture_reload_reg == $past(q.cnt[3]))
      else $error("capture register missed latch");

   a_flag_sticky: assert property (
      @(posedge pclk) disable iff (!presetn)
      (q.flags[4] && !wr) |=> q.flags[4])
      else $error("wrap flag cleared by itself");

   a_toggle_clocks_aux: assert property (
      @(posedge pclk) disable iff (!presetn)
      (en[0] && q.ctl[0][`GTU_F_TGL_SRC] && !wr)
         |=> q.cnt[0] != $past(q.cnt[0]))
      else $error("aux a missed a toggle edge");

   a_core_stopped: assert property (
      @(posedge pclk) disable iff (!presetn)
      (q.ctl[1][`GTU_F_MODE] == GTU_TIMER && !q.ctl[1][`GTU_F_RUN] && !wr &&
       rl[2:0] == '0) |=> $stable(q.cnt[1]))
      else $error("core counted while stopped");

endmodule // gtu_unit
`default_nettype wire

// [verification/gtu_pin_model.sv]
// far side of the timer unit: pin levels for count, gate, direction, capture
// assumes every call starts just after a rising pclk edge
`timescale 1ns/10ps
`default_nettype none
module gtu_pin_model (
   input wire logic pclk,
   output var gtu_pkg::gtu_pins_t pins
);
   import gtu_pkg::*;
   logic [6:0] lv = 7'h00;
   assign pins = gtu_pins_t'(lv);
   // four edges each way so the two-flop sync cannot miss a pulse
   task automatic pulse(input int idx);
      lv[idx] <= 1'b1;
      repeat (4) @(posedge pclk);
      lv[idx] <= 1'b0;
      repeat (4) @(posedge pclk);
   endtask
   task automatic level(input int idx, input logic v);
      lv[idx] <= v;
   endtask
endmodule // gtu_pin_model
`default_nettype wire

// [verification/testbench.sv]
// self-checking bench for the timer unit over apb
// assumes gtu_pkg, gtu_unit and gtu_pin_model are compiled first
`timescale 1ns/10ps
`default_nettype none
`include "gtu_params.svh"
module testbench;
   import gtu_pkg::*;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   gtu_pins_t pins;
   logic slow_toggle_out;
   logic fast_toggle_out;
   logic timebase_pulse;
   logic [`GTU_NUM_TIMERS-1:0] irq_req;
   int err_total = 0;
   int checked = 0;
   int pulses = 0;
   int flips = 0;
   int f0;
   int p0;
   logic tgl_p = 1'b0;
   logic [31:0] rd;
   logic er;
   always #25 pclk = ~pclk;
   // counted by nba so the sequence reads a settled value at the edge
   always @(posedge pclk) if (timebase_pulse === 1'b1) pulses <= pulses + 1;
   always @(posedge pclk) begin
      if (slow_toggle_out !== tgl_p) flips <= flips + 1;
      tgl_p <= slow_toggle_out;
   end
   gtu_unit #(.ADDR_W(12)) gtu_unit_i (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .pins(pins), .slow_toggle_out(slow_toggle_out),
      .fast_toggle_out(fast_toggle_out), .timebase_pulse(timebase_pulse),
      .irq_req(irq_req));
   gtu_pin_model gtu_pin_model_i (.pclk(pclk), .pins(pins));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         err_total++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // holds the request until pready is seen; only the watchdog ends a wait
   task automatic apb(input logic w, input logic [11:0] a,
      input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      pwrite <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0000_0000);
      chk(rd, exp);
   endtask
   function automatic logic [11:0] cta(input int i);
      return 12'(`GTU_CTL_BASE + 4 * i);
   endfunction
   function automatic logic [11:0] cna(input int i);
      return 12'(`GTU_CNT_BASE + 4 * i);
   endfunction
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", checked, err_total);
      if (err_total == 0 && checked > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   initial begin
      repeat (5000) @(posedge pclk);
      err_total++;
      wrap_up();
   end
   initial begin
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      chk(32'(irq_req), 32'h0000_0000);
      rdc(cta(1), 32'h0000_0000);
      rdc(12'(`GTU_STATUS_OFS), 32'h0000_0000);
      apb(1'b0, 12'h030, 32'h0000_0000);
      chk({31'h0, er}, 32'h0000_0001);
      chk(rd, 32'h0000_0000);
      apb(1'b1, 12'h016, 32'h0000_1111);
      chk({31'h0, er}, 32'h0000_0001);
      $display("test reset done");
      for (int i = 0; i < 5; i++) begin
         wr(cna(i), 32'hFFFF_0000 | 32'(16'hA5C0 + i));
         rdc(cna(i), 32'(16'hA5C0 + i));
      end
      $display("test registers done");
      // slow core up from FFFE: one wrap within 24 cycles
      wr(cna(1), 32'h0000_FFFE);
      wr(cta(1), 32'h0000_2008);
      repeat (40) @(posedge pclk);
      chk({31'h0, slow_toggle_out}, 32'h0000_0001);
      wr(cta(1), 32'h0000_0000);
      rdc(12'(`GTU_STATUS_OFS), 32'h0000_0102);
      wr(12'(`GTU_STATUS_OFS), 32'h0000_0002);
      rdc(12'(`GTU_STATUS_OFS), 32'h0000_0100);
      $display("test slow wrap done");
      wr(cna(4), 32'h0000_0001);
      wr(cta(4), 32'h0000_200C);
      repeat (30) @(posedge pclk);
      // toggle pin is gated by the control bit: look before stopping
      chk(32'(irq_req), 32'h0000_0010);
      chk({31'h0, fast_toggle_out}, 32'h0000_0001);
      chk(32'(pulses), 32'h0000_0001);
      wr(cta(4), 32'h0000_0000);
      $display("test fast underflow done");
      wr(cta(0), 32'h0000_0000);
      wr(cna(0), 32'h0000_0000);
      wr(cta(0), 32'h0000_010A);
      repeat (3) gtu_pin_model_i.pulse(0);
      rdc(cna(0), 32'h0000_0003);
      wr(cna(1), 32'h0000_1234);
      wr(cta(0), 32'h0000_010B);
      gtu_pin_model_i.pulse(0);
      rdc(cna(0), 32'h0000_1234);
      wr(cna(2), 32'h0000_5555);
      wr(cta(2), 32'h0000_050B);
      gtu_pin_model_i.pulse(2);
      rdc(cna(1), 32'h0000_5555);
      $display("test capture reload done");
      wr(cta(2), 32'h0000_0000);
      wr(cna(3), 32'h0000_ABCD);
      wr(cta(3), 32'h0007_0000);
      gtu_pin_model_i.pulse(6);
      rdc(12'(`GTU_CAPTURE_RELOAD_REG_OFS), 32'h0000_ABCD);
      rdc(cna(3), 32'h0000_0000);
      $display("test fast capture done");
      // gate closed: no count; open for 40 cycles: exactly five ticks
      wr(cna(2), 32'h0000_0000);
      wr(cta(2), 32'h0000_0089);
      repeat (40) @(posedge pclk);
      rdc(cna(2), 32'h0000_0000);
      gtu_pin_model_i.level(2, 1'b1);
      repeat (40) @(posedge pclk);
      gtu_pin_model_i.level(2, 1'b0);
      repeat (8) @(posedge pclk);
      rdc(cna(2), 32'h0000_0005);
      $display("test gated done");
      // core direction from pin: 40 enabled cycles, five ticks down
      gtu_pin_model_i.level(5, 1'b1);
      wr(cna(1), 32'h0000_0010);
      wr(cta(1), 32'h0000_1008);
      repeat (37) @(posedge pclk);
      wr(cta(1), 32'h0000_0000);
      gtu_pin_model_i.level(5, 1'b0);
      rdc(cna(1), 32'h0000_000B);
      $display("test direction pin done");
      // one core wrap flips the toggle once: aux a counts it
      wr(cna(0), 32'h0000_0000);
      wr(cta(0), 32'h0000_0B0A);
      wr(cna(1), 32'h0000_FFFE);
      wr(cta(1), 32'h0000_0008);
      repeat (40) @(posedge pclk);
      wr(cta(1), 32'h0000_0000);
      rdc(cna(0), 32'h0000_0001);
      $display("test toggle clock done");
      // reloads alternate: high four ticks, low two, 48-cycle period
      wr(cna(0), 32'h0000_FFFE);
      wr(cna(2), 32'h0000_FFFC);
      wr(cta(0), 32'h0000_4603);
      wr(cta(2), 32'h0000_4503);
      wr(cna(1), 32'h0000_FFFF);
      wr(cta(1), 32'h0000_2008);
      repeat (50) @(posedge pclk);
      f0 = flips;
      repeat (192) @(posedge pclk);
      chk(32'(flips - f0), 32'h0000_0008);
      wr(cta(1), 32'h0000_0000);
      rdc(cna(2), 32'h0000_FFFC);
      $display("test pwm done");
      // fast core reloads 3 on each underflow: a pulse every 16 cycles
      wr(12'(`GTU_CAPTURE_RELOAD_REG_OFS), 32'h0000_0003);
      wr(cna(4), 32'h0000_0000);
      wr(cta(4), 32'h0000_800C);
      repeat (20) @(posedge pclk);
      p0 = pulses;
      repeat (192) @(posedge pclk);
      chk(32'(pulses - p0), 32'h0000_000C);
      wr(cta(4), 32'h0000_0000);
      $display("test fast reload done");
      wrap_up();
   end
endmodule // testbench
`default_nettype wire
